// ---- design/pgc_pkg.sv ----
package pgc_pkg;
	localparam int          PGC_PINS        = 7;
	localparam int          PGC_REG_W       = 8;
	localparam logic [11:0] PGC_OFS_PULLUP  = 12'h000;
	localparam logic [11:0] PGC_OFS_SLEW    = 12'h004;
	localparam logic [11:0] PGC_OFS_DRIVE   = 12'h008;
	localparam logic [11:0] PGC_OFS_DIR     = 12'h00C;
	localparam logic [11:0] PGC_OFS_STATUS  = 12'h010;
	localparam logic [7:0]  PGC_RST_PULLUP  = 8'h00;
	localparam logic [7:0]  PGC_RST_SLEW    = 8'h00;
	localparam logic [7:0]  PGC_RST_DRIVE   = 8'h00;
	localparam logic [7:0]  PGC_RST_DIR     = 8'h00;
	localparam logic [7:0]  PGC_WR_MASK     = 8'h7F;
	localparam int          PGC_DIR_OUTPUT  = 1;

	typedef enum logic [1:0] {
		PGC_IDLE,
		PGC_ACCESS
	} pgc_phase_type;
endpackage : pgc_pkg

// ---- design/pgc_pin_qual.sv ----
`timescale 1ns/1ps
// one pin's pad qualification from its direction bit
module pgc_pin_qual
	import pgc_pkg::*;
(
	input  wire logic dir_out,
	input  wire logic pullup_bit,
	input  wire logic slew_bit,
	input  wire logic drive_bit,
	output logic      pad_pullup,
	output logic      pad_slew,
	output logic      pad_drive,
	output logic      pad_drv_en
);
	always_comb begin
		pad_drv_en = dir_out;
		pad_pullup = pullup_bit & ~dir_out;
		pad_slew   = slew_bit & dir_out;
		// drive strength only matters while driving; idle it low as an input
		pad_drive  = drive_bit & dir_out;
	end
endmodule // pgc_pin_qual

// ---- design/pgc_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - one pull-up enable bit per pin 0..6; 1 on, 0 off
// - an output pin always has its pull-up off, whatever its enable bit
// - one slew bit per pin; 1 enables slew limiting on the driver
// - for an input pin the slew bit has no effect on the pad
// - one drive bit per pin; 0 low drive, 1 high drive
// - direction bit: 0 input driver off, 1 output driver on; qualifies settings
// - after reset every pin is a high-impedance input, pull-up off
module pgc_top
	import pgc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [6:0]  port_data_bits,
	output logic      [6:0]  pad_pullup_en,
	output logic      [6:0]  pad_slew_en,
	output logic      [6:0]  pad_drive_high,
	output logic      [6:0]  pad_driver_en,
	output logic      [6:0]  pad_data_out
);
	typedef struct packed {
		logic [7:0]    pullup_enable;
		logic [7:0]    slew_rate_enable;
		logic [7:0]    drive_strength_select;
		logic [7:0]    pin_direction_bits;
		logic [31:0]   prdata;
		logic          pready;
		logic          pslverr;
		pgc_phase_type phase;
		logic [6:0]    pad_pullup;
		logic [6:0]    pad_slew;
		logic [6:0]    pad_drive;
		logic [6:0]    pad_drv_en;
		logic [6:0]    pad_data;
	} pgc_state_type;

	pgc_state_type cur_ff;
	pgc_state_type nxt_ff;

	logic [6:0] q_pullup;
	logic [6:0] q_slew;
	logic [6:0] q_drive;
	logic [6:0] q_drv_en;

	genvar gi;
	generate
		for (gi = 0; gi < PGC_PINS; gi++) begin : g_pin
			pgc_pin_qual u_qual (
				.dir_out    (cur_ff.pin_direction_bits[gi]),
				.pullup_bit (cur_ff.pullup_enable[gi]),
				.slew_bit   (cur_ff.slew_rate_enable[gi]),
				.drive_bit  (cur_ff.drive_strength_select[gi]),
				.pad_pullup (q_pullup[gi]),
				.pad_slew   (q_slew[gi]),
				.pad_drive  (q_drive[gi]),
				.pad_drv_en (q_drv_en[gi])
			);
		end
	endgenerate

	logic       setup;
	logic       wr_lane0;
	logic [7:0] wbyte;

	always_comb begin
		nxt_ff   = cur_ff;
		setup    = psel & ~penable;
		wr_lane0 = pstrb[0];
		wbyte    = pwdata[7:0] & PGC_WR_MASK;
		nxt_ff.pready  = 1'b0;
		nxt_ff.pslverr = 1'b0;
		case (cur_ff.phase)
			PGC_IDLE: begin
				// answer in the access phase that follows each setup: one wait-free access
				if (setup) begin
					nxt_ff.phase  = PGC_ACCESS;
					nxt_ff.pready = 1'b1;
					nxt_ff.prdata = 32'h0000_0000;
					case (paddr)
						PGC_OFS_PULLUP: begin
							nxt_ff.prdata[7:0] = cur_ff.pullup_enable;
						end
						PGC_OFS_SLEW: begin
							nxt_ff.prdata[7:0] = cur_ff.slew_rate_enable;
						end
						PGC_OFS_DRIVE: begin
							nxt_ff.prdata[7:0] = cur_ff.drive_strength_select;
						end
						PGC_OFS_DIR: begin
							nxt_ff.prdata[7:0] = cur_ff.pin_direction_bits;
						end
						PGC_OFS_STATUS: begin
							nxt_ff.prdata[6:0] = cur_ff.pad_pullup;
							nxt_ff.prdata[14:8] = cur_ff.pad_slew;
							nxt_ff.prdata[22:16] = cur_ff.pad_drive;
							nxt_ff.prdata[30:24] = cur_ff.pad_drv_en;
						end
						default: begin
							nxt_ff.pslverr = 1'b1;
						end
					endcase
					if (pwrite) begin
						nxt_ff.prdata = 32'h0000_0000;
						if (paddr == PGC_OFS_STATUS) begin
							nxt_ff.pslverr = 1'b1;
						end
					end
				end
			end
			PGC_ACCESS: begin
				nxt_ff.phase = PGC_IDLE;
				// writes commit at the edge where pready is sampled high
				if (psel & penable & pwrite & wr_lane0) begin
					case (paddr)
						PGC_OFS_PULLUP: nxt_ff.pullup_enable = wbyte;
						PGC_OFS_SLEW:   nxt_ff.slew_rate_enable = wbyte;
						PGC_OFS_DRIVE:  nxt_ff.drive_strength_select = wbyte;
						PGC_OFS_DIR:    nxt_ff.pin_direction_bits = wbyte;
						default: begin
						end
					endcase
				end
			end
			default: begin
				nxt_ff.phase = PGC_IDLE;
			end
		endcase
		// pads follow the qualified settings one cycle later so outputs are registered
		nxt_ff.pad_pullup = q_pullup;
		nxt_ff.pad_slew   = q_slew;
		nxt_ff.pad_drive  = q_drive;
		nxt_ff.pad_drv_en = q_drv_en;
		nxt_ff.pad_data   = port_data_bits & q_drv_en;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cur_ff <= '0;
			cur_ff.pullup_enable <= PGC_RST_PULLUP;
			cur_ff.slew_rate_enable <= PGC_RST_SLEW;
			cur_ff.drive_strength_select <= PGC_RST_DRIVE;
			cur_ff.pin_direction_bits <= PGC_RST_DIR;
			cur_ff.phase <= PGC_IDLE;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	assign prdata         = cur_ff.prdata;
	assign pready         = cur_ff.pready;
	assign pslverr        = cur_ff.pslverr;
	assign pad_pullup_en  = cur_ff.pad_pullup;
	assign pad_slew_en    = cur_ff.pad_slew;
	assign pad_drive_high = cur_ff.pad_drive;
	assign pad_driver_en  = cur_ff.pad_drv_en;
	assign pad_data_out   = cur_ff.pad_data;

	// assertions
	AST_PULLUP_OFF_OUT: assert property (@(posedge clock) disable iff (!rst_n)
		(cur_ff.pin_direction_bits[0] && $stable(cur_ff.pin_direction_bits)) |=> !pad_pullup_en[0])
		else $error("pull-up on for an output pin");
	AST_PULLUP_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> pad_pullup_en == ($past(cur_ff.pullup_enable[6:0]) & ~$past(cur_ff.pin_direction_bits[6:0])))
		else $error("pull-up output does not match enable and direction");
	AST_SLEW_INPUT: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> ((pad_slew_en & ~$past(cur_ff.pin_direction_bits[6:0])) == 7'h00))
		else $error("slew active on an input pin");
	AST_SLEW_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> pad_slew_en == ($past(cur_ff.slew_rate_enable[6:0]) & $past(cur_ff.pin_direction_bits[6:0])))
		else $error("slew output does not match register");
	AST_DRIVE_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> pad_drive_high == ($past(cur_ff.drive_strength_select[6:0]) & $past(cur_ff.pin_direction_bits[6:0])))
		else $error("drive output does not match register");
	AST_DRV_EN_DIR: assert property (@(posedge clock) disable iff (!rst_n)
		1'b1 |=> pad_driver_en == $past(cur_ff.pin_direction_bits[6:0]))
		else $error("driver enable does not follow direction");
	sequence s_reset_rel;
		!rst_n ##1 rst_n;
	endsequence
	AST_RESET_INPUTS: assert property (@(posedge clock)
		s_reset_rel |-> (pad_driver_en == 7'h00 && pad_pullup_en == 7'h00))
		else $error("pins not high-impedance inputs after reset");
	AST_BIT7_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		!cur_ff.pullup_enable[7] && !cur_ff.slew_rate_enable[7] && !cur_ff.drive_strength_select[7])
		else $error("bit 7 of a control register set");
	sequence s_wr_pullup;
		psel && !penable && pwrite && pstrb[0] && paddr == PGC_OFS_PULLUP ##1 psel && penable && pready;
	endsequence
	AST_WRITE_PULLUP: assert property (@(posedge clock) disable iff (!rst_n)
		s_wr_pullup |=> cur_ff.pullup_enable == ($past(pwdata[7:0]) & PGC_WR_MASK))
		else $error("pull-up register write not stored");
endmodule // pgc_top

// ---- bench/pgc_pad_model.sv ----
`timescale 1ns/1ps
// pin seen by the outside: driven, pulled up, or floating
module pgc_pad_model (
	input  wire logic       clock,
	input  wire logic [6:0] drv_en,
	input  wire logic [6:0] data_out,
	input  wire logic [6:0] pullup_en,
	output logic      [6:0] pin_level
);
	logic [6:0] float_ff = 7'h00;
	// a floating pin toggles so it never passes for a settled level
	always @(posedge clock) float_ff <= ~float_ff;
	assign pin_level = (drv_en & data_out) | (~drv_en & (pullup_en | float_ff));
endmodule // pgc_pad_model

// ---- bench/pgc_top_tb.sv ----
`timescale 1ns/1ps
module pgc_top_tb;
	import pgc_pkg::*;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	logic [6:0]  pdb, pu, sl, ds, en, dout, pin, dir;
	int          num_errors = 0;
	int          compares = 0;
	logic [11:0] ofs [4] = '{PGC_OFS_DIR, PGC_OFS_PULLUP, PGC_OFS_SLEW, PGC_OFS_DRIVE};
	// rows: direction, pull-up, slew, drive
	logic [6:0]  rows [3][4] = '{'{7'h00, 7'h7F, 7'h7F, 7'h7F}, '{7'h7F, 7'h7F, 7'h00, 7'h55},
		'{7'h55, 7'h2A, 7'h7F, 7'h7F}};
	pgc_top dut_u (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .port_data_bits(pdb), .pad_pullup_en(pu), .pad_slew_en(sl),
		.pad_drive_high(ds), .pad_driver_en(en), .pad_data_out(dout));
	pgc_pad_model pad_u (.clock(clock), .drv_en(en), .data_out(dout), .pullup_en(pu), .pin_level(pin));
	task automatic results();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int n;
		@(posedge clock);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
		@(posedge clock);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (pready !== 1'b1) begin
			num_errors++;
			results();
		end
		psel <= 0;
		penable <= 0;
	endtask
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	initial begin
		rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 0; pdb = 7'h2A;
		repeat (5) @(posedge clock);
		rst_n <= 1;
		chk({pu, sl, ds, en, 4'h0}, 32'h0);
		for (int j = 0; j < 4; j++) begin
			apb(0, ofs[j], 32'h0, 4'h0);
			chk(rd, 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			for (int j = 0; j < 4; j++)
				apb(1, ofs[j], {24'h0, 1'b1, rows[i][j]}, 4'hF);
			dir = rows[i][0];
			repeat (2) @(posedge clock);
			chk({pu, sl, ds, en, 4'h0}, {rows[i][1] & ~dir, rows[i][2] & dir, rows[i][3] & dir, dir, 4'h0});
			chk({dout, pin & (dir | rows[i][1])}, {pdb & dir, (pdb & dir) | (rows[i][1] & ~dir)});
			for (int j = 1; j < 4; j++) begin
				apb(0, ofs[j], 32'h0, 4'h0);
				chk(rd, {25'h0, rows[i][j]});
			end
		end
		apb(1, PGC_OFS_SLEW, 32'h0, 4'h0);
		apb(0, PGC_OFS_SLEW, 32'h0, 4'h0);
		chk({er, rd}, {1'b0, 32'h7F});
		apb(0, 12'h014, 32'h0, 4'h0);
		chk({er, rd}, {1'b1, 32'h0});
		apb(1, PGC_OFS_STATUS, 32'hFF, 4'hF);
		chk(er, 1);
		rst_n <= 0;
		repeat (2) @(posedge clock);
		chk({pu, sl, ds, en, 4'h0}, 32'h0);
		rst_n <= 1;
		apb(0, PGC_OFS_PULLUP, 32'h0, 4'h0);
		chk(rd, 32'h0);
		results();
	end
endmodule // pgc_top_tb
